// ===== adcc_top.v
// converter control: registers on ahb-lite, conversion sequencing, input and reference select
// What this block does
// - channel code 1111 routes temperature sensor single-ended and enables it
// - temperature channel works with single conversion mode
// - reference field bits 7,6,4; change mid-conversion applies after completion
// - any reference change makes the next conversion 25 converter clocks
// - reference codes: supply, external pin, 1.1 V, 2.56 V with bypass choice
// - alignment bit 5 set left-adjusts result, clear right-adjusts
// - alignment change alters result presentation immediately
// - channel codes 0000 to 0011 pick single-ended inputs zero to three
// - codes 0100 to 1011 differential; even code gain 1x, odd 20x
// - same input on both terminals gives offset measurement
// - channel change mid-conversion applies after completion
// - enable bit 7 powers converter; clearing aborts any conversion
// - start bit 6 begins each single conversion, first free-running one
// - first conversion after enable or a reference change takes 25 clocks, later ones 13
// - start bit reads one while busy; writing zero does nothing
// - with auto-trigger bit 5 set a rising trigger edge starts conversion
// - done flag bit 4 set when conversion ends and result updated
// - interrupt only when flag, enable bit 3 and global enable all set
// - flag clears on vector execution or writing one; zero leaves it
// - prescaler divides system clock by 2 to 128
// - trigger source codes free-running then six event sources
// - after low byte read, result frozen until high byte read
`timescale 1ns/10ps
`default_nettype none
`include "adcc_regs.vh"
module adcc_top (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output wire        o_hreadyout,
  output wire        o_hresp,
  output reg  [31:0] o_hrdata,
  input  wire [5:0]  i_trig_flags,
  input  wire        i_global_ie,
  input  wire        i_vector_ack,
  input  wire [9:0]  i_sar_result,
  output wire        o_irq,
  output reg         o_conv_power,
  output reg         o_conv_busy,
  output reg         o_conv_done,
  output reg  [2:0]  o_ref_sel,
  output reg         o_int_ref_on,
  output reg         o_ref_pin_used,
  output reg  [2:0]  o_pos_input,
  output reg  [2:0]  o_neg_input,
  output reg         o_diff_mode,
  output reg         o_gain_20x,
  output reg         o_bandgap_sel,
  output reg         o_gnd_sel,
  output reg         o_temp_sensor_en
);
  // channel decode: {temp, gnd, bandgap, gain20, diff, neg[2:0], pos[2:0]}
  function [10:0] chan_dec;
    input [3:0] c;
    begin
      chan_dec = 11'h000;
      case (c)
        4'h0, 4'h1, 4'h2, 4'h3:
          chan_dec = {8'h00, 1'b0, c[1:0]};
        4'h4, 4'h5:
          chan_dec = {3'h0, c[0], 1'b1, 3'h2, 3'h2};
        4'h6, 4'h7:
          chan_dec = {3'h0, c[0], 1'b1, 3'h3, 3'h2};
        4'h8, 4'h9:
          chan_dec = {3'h0, c[0], 1'b1, 3'h0, 3'h0};
        4'ha, 4'hb:
          chan_dec = {3'h0, c[0], 1'b1, 3'h1, 3'h0};
        `ADCC_CH_BANDGAP:
          chan_dec = 11'h100;
        `ADCC_CH_GND:
          chan_dec = 11'h200;
        `ADCC_CH_TEMP:
          chan_dec = {3'h4, 5'h00, 3'h4};
        default:
          chan_dec = 11'h000;
      endcase
    end
  endfunction

  // reference decode: {internal on, pin used}; code 10x is treated as supply
  function [1:0] ref_dec;
    input [2:0] r;
    begin
      case (r)
        3'h1:       ref_dec = 2'b01;
        3'h2, 3'h6: ref_dec = 2'b10;
        3'h3, 3'h7: ref_dec = 2'b11;
        default:    ref_dec = 2'b00;
      endcase
    end
  endfunction

  // software-visible registers
  reg  [7:0] mux_r;
  reg        en_r;
  reg        ate_r;
  reg        flag_r;
  reg        ie_r;
  reg  [2:0] ps_r;
  reg  [2:0] ts_r;
  reg  [9:0] result_r;
  reg        lock_r;

  // conversion state
  reg        busy_r;
  reg  [4:0] cyc_r;
  reg        long_r;
  reg        en_prev_r;
  reg  [3:0] chan_app_r;
  reg  [2:0] ref_app_r;

  // bus state
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg  [11:0] addr_r;

  wire       tick;
  wire       trig_edge;
  wire [2:0] ref_field;
  wire       addr_ph;
  wire       wr_data_ph;
  wire       done;
  wire       sw_start;
  wire       hw_start;
  wire       start;
  wire       free_run;
  wire [4:0] conv_len;
  reg  [7:0] rd_val;
  // control word write and the enable that it carries
  wire       en_wr;
  wire       en_now;

  // reset image of the control word, split into its fields on reset
  localparam [7:0] CSRA_RST = `ADCC_RST_CSRA;

  assign ref_field = {mux_r[`ADCC_B_REF2], mux_r[`ADCC_B_REF1], mux_r[`ADCC_B_REF0]};

  // converter clock derived from the system clock
  adcc_prescaler u_presc (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_run     (en_r),
    .i_div_sel (ps_r),
    .o_tick    (tick)
  );

  adcc_trigger u_trig (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_src_sel   (ts_r),
    .i_src_flags (i_trig_flags),
    .o_edge      (trig_edge)
  );

  // ahb-lite: writes take no wait state, reads take one so read data is registered
  assign addr_ph     = i_hsel && i_htrans[1] && i_hready;
  assign wr_data_ph  = wr_pend_r;
  assign o_hreadyout = !rd_pend_r;
  assign o_hresp     = 1'b0;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end else begin
      wr_pend_r <= addr_ph && i_hwrite;
      rd_pend_r <= addr_ph && !i_hwrite;
      if (addr_ph)
        addr_r <= i_haddr[11:0];
    end
  end

  // read mux; the alignment bit is applied here so a change shows at once
  always @* begin
    rd_val = 8'h00;
    case (addr_r)
      `ADCC_OFS_MUX:  rd_val = mux_r;
      `ADCC_OFS_CSRA: rd_val = {en_r, busy_r, ate_r, flag_r, ie_r, ps_r};
      `ADCC_OFS_CSRB: rd_val = {5'h00, ts_r};
      `ADCC_OFS_RESL:
        rd_val = mux_r[`ADCC_B_LADJ] ? {result_r[1:0], 6'h00} : result_r[7:0];
      `ADCC_OFS_RESH:
        rd_val = mux_r[`ADCC_B_LADJ] ? result_r[9:2] : {6'h00, result_r[9:8]};
      default:        rd_val = 8'h00;
    endcase
  end

  // unmapped addresses read as zero
  always @(posedge i_ref_clk) begin
    if (i_rst)
      o_hrdata <= 32'h0000_0000;
    else if (rd_pend_r)
      o_hrdata <= {24'h00_0000, rd_val};
  end

  // low-byte read freezes the result until the high byte is read
  always @(posedge i_ref_clk) begin
    if (i_rst)
      lock_r <= 1'b0;
    else if (rd_pend_r && addr_r == `ADCC_OFS_RESL)
      lock_r <= 1'b1;
    else if (rd_pend_r && addr_r == `ADCC_OFS_RESH)
      lock_r <= 1'b0;
  end

  // start sources: software write of one, trigger edge, or free-running restart
  assign free_run = ate_r && (ts_r == `ADCC_TS_FREE);
  assign sw_start = wr_data_ph && addr_r == `ADCC_OFS_CSRA && i_hwdata[`ADCC_B_START];
  assign hw_start = ate_r && !free_run && trig_edge;
  assign done     = busy_r && tick && (cyc_r == conv_len - 5'h01);
  // a start written in the same word as enable is taken at once
  assign en_wr    = wr_data_ph && addr_r == `ADCC_OFS_CSRA;
  assign en_now   = en_wr ? i_hwdata[`ADCC_B_EN] : en_r;
  assign start    = en_now && !busy_r &&
                    (sw_start || hw_start || (free_run && o_conv_done));
  assign conv_len = long_r ? `ADCC_CYC_LONG : `ADCC_CYC_NORMAL;

  // control register writes; hardware set of the flag wins over a clear
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      mux_r  <= `ADCC_RST_MUX;
      en_r   <= CSRA_RST[`ADCC_B_EN];
      ate_r  <= CSRA_RST[`ADCC_B_ATE];
      ie_r   <= CSRA_RST[`ADCC_B_IE];
      ps_r   <= CSRA_RST[2:0];
      ts_r   <= `ADCC_RST_CSRB;
      flag_r <= CSRA_RST[`ADCC_B_FLAG];
    end else begin
      if (wr_data_ph && addr_r == `ADCC_OFS_MUX)
        mux_r <= i_hwdata[7:0];
      if (wr_data_ph && addr_r == `ADCC_OFS_CSRB)
        ts_r <= i_hwdata[2:0];
      if (wr_data_ph && addr_r == `ADCC_OFS_CSRA) begin
        en_r  <= i_hwdata[`ADCC_B_EN];
        ate_r <= i_hwdata[`ADCC_B_ATE];
        ie_r  <= i_hwdata[`ADCC_B_IE];
        ps_r  <= i_hwdata[2:0];
      end
      if (done)
        flag_r <= 1'b1;
      else if (i_vector_ack)
        flag_r <= 1'b0;
      else if (wr_data_ph && addr_r == `ADCC_OFS_CSRA && i_hwdata[`ADCC_B_FLAG])
        flag_r <= 1'b0;
    end
  end

  // conversion sequencer counts converter clock ticks
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_r    <= 1'b0;
      cyc_r     <= 5'h00;
      long_r    <= 1'b0;
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= en_r;
      // start first, so a start written with enable is not lost to the off branch
      if (start) begin
        busy_r <= 1'b1;
        cyc_r  <= 5'h00;
      end else if (!en_r) begin
        busy_r <= 1'b0;
        cyc_r  <= 5'h00;
      end else if (done) begin
        busy_r <= 1'b0;
        cyc_r  <= 5'h00;
        long_r <= 1'b0;
      end else if (busy_r && tick) begin
        cyc_r <= cyc_r + 5'h01;
      end
      // enabling arms the initialising conversion
      if (en_r && !en_prev_r)
        long_r <= 1'b1;
      // a changed reference also arms a long conversion
      if (!busy_r && ref_field != ref_app_r)
        long_r <= 1'b1;
    end
  end

  // result written in the same cycle the flag sets, unless frozen by a low-byte read;
  // a low-byte read in the completion cycle freezes too, so both bytes stay one sample
  always @(posedge i_ref_clk) begin
    if (i_rst)
      result_r <= 10'h000;
    else if (done && !lock_r && !(rd_pend_r && addr_r == `ADCC_OFS_RESL))
      result_r <= i_sar_result;
  end

  // channel and reference follow the register only between conversions
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      chan_app_r <= 4'h0;
      ref_app_r  <= 3'h0;
    end else if (!busy_r) begin
      chan_app_r <= mux_r[3:0];
      ref_app_r  <= ref_field;
    end
  end

  // registered analog-side controls
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_conv_power     <= 1'b0;
      o_conv_busy      <= 1'b0;
      o_conv_done      <= 1'b0;
      o_ref_sel        <= 3'h0;
      o_int_ref_on     <= 1'b0;
      o_ref_pin_used   <= 1'b0;
      o_pos_input      <= 3'h0;
      o_neg_input      <= 3'h0;
      o_diff_mode      <= 1'b0;
      o_gain_20x       <= 1'b0;
      o_bandgap_sel    <= 1'b0;
      o_gnd_sel        <= 1'b0;
      o_temp_sensor_en <= 1'b0;
    end else begin
      o_conv_power <= en_r;
      // busy drops with power, so an abort never shows busy while off
      o_conv_busy  <= busy_r && en_r;
      o_conv_done  <= done;
      o_ref_sel    <= ref_app_r;
      {o_int_ref_on, o_ref_pin_used} <= ref_dec(ref_app_r);
      {o_temp_sensor_en, o_gnd_sel, o_bandgap_sel, o_gain_20x, o_diff_mode,
       o_neg_input, o_pos_input} <= chan_dec(chan_app_r);
    end
  end

  // interrupt request needs flag, local enable and processor global enable
  assign o_irq = flag_r && ie_r && i_global_ie;
endmodule
`default_nettype wire

// ===== adcc_regs.vh
// register map, field positions, reset values and cycle counts of the converter control
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
`define ADCC_OFS_MUX       12'h000
`define ADCC_OFS_CSRA      12'h004
`define ADCC_OFS_CSRB      12'h008
`define ADCC_OFS_RESL      12'h00c
`define ADCC_OFS_RESH      12'h010
`define ADCC_RST_MUX       8'h00
`define ADCC_RST_CSRA      8'h00
`define ADCC_RST_CSRB      3'h0
`define ADCC_B_REF2        7
`define ADCC_B_REF1        6
`define ADCC_B_LADJ        5
`define ADCC_B_REF0        4
`define ADCC_B_EN          7
`define ADCC_B_START       6
`define ADCC_B_ATE         5
`define ADCC_B_FLAG        4
`define ADCC_B_IE          3
`define ADCC_CH_TEMP       4'hf
`define ADCC_CH_BANDGAP    4'hc
`define ADCC_CH_GND        4'hd
`define ADCC_TS_FREE       3'h0
`define ADCC_CYC_NORMAL    5'h0d
`define ADCC_CYC_LONG      5'h19
`endif

// ===== adcc_prescaler.v
// converter clock divider: one-cycle tick per converter clock period
`timescale 1ns/10ps
`default_nettype none
module adcc_prescaler (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_run,
  input  wire [2:0] i_div_sel,
  output wire       o_tick
);
  reg  [6:0] cnt_r;
  reg  [6:0] mask;

  // division of two for codes 0 and 1, doubling from there
  always @* begin
    case (i_div_sel)
      3'h0, 3'h1: mask = 7'h01;
      3'h2:       mask = 7'h03;
      3'h3:       mask = 7'h07;
      3'h4:       mask = 7'h0f;
      3'h5:       mask = 7'h1f;
      3'h6:       mask = 7'h3f;
      default:    mask = 7'h7f;
    endcase
  end

  // held at zero while off so the first period is whole
  always @(posedge i_ref_clk) begin
    if (i_rst || !i_run)
      cnt_r <= 7'h00;
    else
      cnt_r <= cnt_r + 7'h01;
  end

  assign o_tick = i_run && ((cnt_r & mask) == mask);
endmodule
`default_nettype wire

// ===== adcc_trigger.v
// auto-trigger source select and rising edge detect
`timescale 1ns/10ps
`default_nettype none
module adcc_trigger (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire [2:0] i_src_sel,
  input  wire [5:0] i_src_flags,
  output wire       o_edge
);
  reg  lvl;
  reg  lvl_prev_r;

  // free-running code selects a constant low, so switching to it never fires
  always @* begin
    if (i_src_sel == 3'h0 || i_src_sel == 3'h7)
      lvl = 1'b0;
    else
      lvl = i_src_flags[i_src_sel - 3'h1];
  end

  // a source switch onto a set flag also counts as an edge
  always @(posedge i_ref_clk) begin
    if (i_rst)
      lvl_prev_r <= 1'b0;
    else
      lvl_prev_r <= lvl;
  end

  assign o_edge = lvl && !lvl_prev_r;
endmodule
`default_nettype wire

// ===== adcc_checker.sv
// concurrent checks on the converter control ports
`timescale 1ns/10ps
`default_nettype none
module adcc_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        i_global_ie,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_irq,
  input wire logic        o_conv_power,
  input wire logic        o_conv_busy,
  input wire logic        o_conv_done,
  input wire logic [2:0]  o_ref_sel,
  input wire logic        o_int_ref_on,
  input wire logic        o_ref_pin_used,
  input wire logic [2:0]  o_pos_input,
  input wire logic        o_diff_mode,
  input wire logic        o_gain_20x,
  input wire logic        o_temp_sensor_en
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // a read data phase has exactly one wait cycle
  read_wait_a: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
    |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait cycle wrong");
  bus_okay_a: assert property (o_hresp == 1'b0 && o_hrdata[31:8] == 24'h0)
    else $error("bad response or read data");
  temp_route_a: assert property (o_temp_sensor_en |-> o_pos_input == 3'h4 && !o_diff_mode)
    else $error("temperature sensor not routed single-ended");
  ref_decode_a: assert property (o_int_ref_on == o_ref_sel[1]
    && o_ref_pin_used == (o_ref_sel == 3'h1 || o_ref_sel[1:0] == 2'h3))
    else $error("reference decode wrong");
  gain_diff_a: assert property (o_gain_20x |-> o_diff_mode)
    else $error("gain without differential pair");
  irq_gate_a: assert property (o_irq |-> i_global_ie)
    else $error("interrupt without global enable");
  // done pulse stands in the last busy cycle and lasts one cycle
  done_pulse_a: assert property (o_conv_done |-> o_conv_busy
    ##1 (!o_conv_busy && !o_conv_done)) else $error("done pulse misplaced");
  abort_idle_a: assert property (!o_conv_power |-> !o_conv_busy)
    else $error("busy while powered off");
  // the fastest conversion is 13 ticks of a divide by 2
  min_length_a: assert property ($fell(o_conv_busy) && o_conv_power
    |-> $past(o_conv_busy, 8)) else $error("conversion too short");
endmodule
bind adcc_top adcc_checker u_adcc_checker (.i_ref_clk, .i_rst, .i_hsel, .i_htrans, .i_hwrite,
  .i_hready, .i_global_ie, .o_hreadyout, .o_hresp, .o_hrdata, .o_irq, .o_conv_power,
  .o_conv_busy, .o_conv_done, .o_ref_sel, .o_int_ref_on, .o_ref_pin_used, .o_pos_input,
  .o_diff_mode, .o_gain_20x, .o_temp_sensor_en);
`default_nettype wire

// ===== adcc_tb_top.sv
// self-checking testbench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_tb_top;
  logic        i_ref_clk, i_rst, i_hsel, i_hwrite, i_global_ie, i_vector_ack;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, s, seed;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize, o_ref_sel, o_pos_input, o_neg_input;
  logic [5:0]  i_trig_flags;
  logic [9:0]  i_sar_result, a;
  logic [7:0]  q, pc;
  wire logic   i_hready;
  logic        o_hreadyout, o_hresp, o_irq, o_conv_power, o_conv_busy, o_conv_done;
  logic        o_int_ref_on, o_ref_pin_used, o_diff_mode, o_gain_20x;
  logic        o_bandgap_sel, o_gnd_sel, o_temp_sensor_en;
  int          n_errors, cmp_count, n, d;
  // the one slave's ready is the bus ready
  assign i_hready = o_hreadyout;
  adcc_top u_adcc_top (.i_ref_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_trig_flags, .i_global_ie,
    .i_vector_ack, .i_sar_result, .o_irq, .o_conv_power, .o_conv_busy, .o_conv_done,
    .o_ref_sel, .o_int_ref_on, .o_ref_pin_used, .o_pos_input, .o_neg_input, .o_diff_mode,
    .o_gain_20x, .o_bandgap_sel, .o_gnd_sel, .o_temp_sensor_en);
  // 100 mhz system clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // {pos, diff, gain, bandgap, gnd, temp, neg} expected for a channel code
  function automatic logic [10:0] chan(input logic [3:0] c);
    logic [2:0] ng;
    ng = {1'b0, ~c[3], c[1]};
    case (c)
      4'h4, 4'h5, 4'h6, 4'h7: chan = {3'h2, 1'b1, c[0], 3'h0, ng};
      4'h8, 4'h9, 4'ha, 4'hb: chan = {3'h0, 1'b1, c[0], 3'h0, ng};
      4'hc: chan = 11'h020;
      4'hd: chan = 11'h010;
      4'he: chan = 11'h000;
      4'hf: chan = 11'h408;
      default: chan = {c[2:0], 8'h00};
    endcase
  endfunction
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one single ahb-lite transfer; read data lands in q
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    int k;
    k = 0;
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, ad};
    i_hwrite <= w;
    do begin @(posedge i_ref_clk); k++; end while (i_hready !== 1'b1 && k < 99);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, wd};
    do begin @(posedge i_ref_clk); k++; end while (i_hready !== 1'b1 && k < 99);
    q = o_hrdata[7:0];
    if (k >= 99) begin
      n_errors++;
      results();
    end
  endtask
  // bounded wait for busy to reach v; n counts the cycles
  task automatic wt(input logic v);
    n = 0;
    while (o_conv_busy !== v && n < 9000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 9000) begin
      n_errors++;
      results();
    end
  endtask
  task automatic run(input logic [7:0] cs);
    ahb(1'b1, 8'h04, cs);
    wt(1'b1);
    wt(1'b0);
  endtask
  initial begin
    {i_hsel, i_hwrite, i_global_ie, i_vector_ack, i_htrans, i_trig_flags} = '0;
    {i_haddr, i_hwdata, i_sar_result} = '0;
    i_hsize = 3'h2;
    i_rst = 1'b1;
    seed = 32'h8720e283;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // reset values and an unmapped word
    ahb(1'b0, 8'h00, 8'h00);
    chk("mux_reset", 8'h00, q);
    ahb(1'b0, 8'h04, 8'h00);
    chk("csra_reset", 8'h00, q);
    ahb(1'b1, 8'h40, 8'hff);
    ahb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    // every channel code, reference code taken from the low bits
    for (int c = 0; c < 16; c++) begin
      ahb(1'b1, 8'h00, {c[2:1], 1'b0, c[0], c[3:0]});
      repeat (3) @(posedge i_ref_clk);
      chk("chan", chan(c[3:0]), {o_pos_input, o_diff_mode, o_gain_20x, o_bandgap_sel,
        o_gnd_sel, o_temp_sensor_en, o_diff_mode ? o_neg_input : 3'h0});
      chk("int_ref", c[1], o_int_ref_on);
      chk("ref_pin", c[2:0] == 3'h1 || c[1:0] == 2'h3, o_ref_pin_used);
      ahb(1'b0, 8'h00, 8'h00);
      chk("mux_rd", {c[2:1], 1'b0, c[0], c[3:0]}, q);
    end
    $display("test channels done");
    // temperature sensor on the 1.1 v reference, single mode
    s = rnd();
    pc = 8'(s % 3 + 1);
    d = 1 << pc;
    ahb(1'b1, 8'h00, 8'h4f);
    ahb(1'b1, 8'h04, 8'h80 | pc);
    s = rnd();
    i_sar_result <= s[9:0];
    run(8'hc0 | pc);
    chk("first_len", 1, n >= 24 * d && n <= 26 * d);
    ahb(1'b0, 8'h04, 8'h00);
    chk("done_csra", 8'h90 | pc, q);
    ahb(1'b0, 8'h0c, 8'h00);
    chk("resl_right", s[7:0], q);
    ahb(1'b0, 8'h10, 8'h00);
    chk("resh_right", {6'h0, s[9:8]}, q);
    ahb(1'b1, 8'h00, 8'h6f);
    ahb(1'b0, 8'h0c, 8'h00);
    chk("resl_left", {s[1:0], 6'h0}, q);
    ahb(1'b0, 8'h10, 8'h00);
    chk("resh_left", s[9:2], q);
    $display("test first conversion done");
    // interrupt gating, vector clear, then write-one clear
    ahb(1'b1, 8'h04, 8'h88 | pc);
    i_global_ie <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    chk("irq_on", 1, o_irq);
    i_global_ie <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("irq_gie_off", 0, o_irq);
    i_global_ie <= 1'b1;
    i_vector_ack <= 1'b1;
    @(posedge i_ref_clk);
    i_vector_ack <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("irq_ack", 0, o_irq);
    run(8'hc8 | pc);
    chk("next_len", 1, n >= 12 * d && n <= 14 * d);
    repeat (2) @(posedge i_ref_clk);
    chk("irq_again", 1, o_irq);
    ahb(1'b1, 8'h04, 8'h98 | pc);
    ahb(1'b0, 8'h04, 8'h00);
    chk("flag_w1c", 8'h88 | pc, q);
    $display("test interrupt done");
    // reference change lengthens the next conversion
    ahb(1'b1, 8'h00, 8'hcc);
    run(8'hc0 | pc);
    chk("ref_len", 1, n >= 24 * d && n <= 26 * d);
    // changes written while busy wait for completion
    ahb(1'b1, 8'h04, 8'hc0 | pc);
    ahb(1'b1, 8'h04, 8'h80 | pc);
    ahb(1'b0, 8'h04, 8'h00);
    chk("start_zero", 1, q[6]);
    ahb(1'b1, 8'h00, 8'h43);
    repeat (3) @(posedge i_ref_clk);
    chk("chan_held", {3'h0, 3'h6}, {o_pos_input, o_ref_sel});
    wt(1'b0);
    repeat (3) @(posedge i_ref_clk);
    chk("chan_new", {3'h3, 3'h2}, {o_pos_input, o_ref_sel});
    // abort by clearing enable mid-conversion
    ahb(1'b1, 8'h04, 8'hc0 | pc);
    ahb(1'b1, 8'h04, 8'h00);
    wt(1'b0);
    chk("abort", 1, n < 4);
    ahb(1'b0, 8'h04, 8'h00);
    chk("abort_csra", 8'h10, q);
    $display("test deferred and abort done");
    // each trigger source starts on a rising flag
    ahb(1'b1, 8'h04, 8'ha0 | pc);
    for (int t = 1; t < 7; t++) begin
      ahb(1'b1, 8'h08, 8'(t));
      i_trig_flags <= 6'(1 << (t - 1));
      wt(1'b1);
      chk("trigger", 1, n < 6);
      wt(1'b0);
      i_trig_flags <= 6'h00;
    end
    // free running restarts by itself after one start
    ahb(1'b1, 8'h08, 8'h00);
    ahb(1'b1, 8'h04, 8'he0 | pc);
    wt(1'b1);
    wt(1'b0);
    wt(1'b1);
    chk("free_run", 1, n < 4);
    ahb(1'b1, 8'h04, 8'h00);
    $display("test triggers done");
    // a start written together with enable runs the long first conversion,
    // then a low byte read freezes the result until the high byte
    s = rnd();
    i_sar_result <= s[9:0];
    run(8'hc0 | pc);
    chk("en_start_len", 1, n >= 24 * d && n <= 26 * d);
    a = s[9:0];
    ahb(1'b0, 8'h0c, 8'h00);
    chk("frz_low", a[7:0], q);
    s = rnd();
    i_sar_result <= s[9:0];
    run(8'hc0 | pc);
    ahb(1'b0, 8'h10, 8'h00);
    chk("frz_high", {6'h0, a[9:8]}, q);
    ahb(1'b0, 8'h0c, 8'h00);
    chk("frz_drop", a[7:0], q);
    $display("test freeze done");
    results();
  end
endmodule
`default_nettype wire
